// file: hdl/shc_pkg.sv
/*
 * Shared constants and types for the sample-and-hold channel control block.
 * Assumes a 100 MHz system clock; pins arrive asynchronously and are
 * synchronised inside the block.
 */
package shc_pkg;
   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_MHZ     = 100;
   localparam int RST_MIN_NS  = 90;
   localparam int RST_MAX_NS  = 200;
   localparam int ACQ_MAX_US  = 16;
   localparam int RST_MIN_CYC = (RST_MIN_NS * CLK_MHZ + 999) / 1000;
   localparam int RST_MAX_CYC = (RST_MAX_NS * CLK_MHZ) / 1000;
   localparam int ACQ_MAX_CYC = ACQ_MAX_US * CLK_MHZ;
   localparam int ACQ_W       = 11;
   localparam int LO_W        = 5;

   // ----------------------------------------------------------------
   // Channels and serial word
   // ----------------------------------------------------------------
   localparam int          NUM_CH   = 32;
   localparam int          IDX_W    = 6;
   localparam logic [5:0]  OFFS_IDX = 6'h20;
   localparam int          SER_BITS = 8;
   localparam int          SER_OFFS = 7;

   typedef struct packed {
      logic       offs;
      logic [4:0] ch;
   } chan_sel_t;

   // ----------------------------------------------------------------
   // Pins and their pull defaults when floating
   // ----------------------------------------------------------------
   localparam int PIN_W = 7;
   typedef struct packed {
      logic cs_sync_n;
      logic wr_n;
      logic offset_sel;
      logic sclk;
      logic sdin;
      logic track_n;
      logic port_choice;
   } pin_in_t;
   localparam logic [6:0] PIN_DEFAULT = 7'h4e;

   // ----------------------------------------------------------------
   // APB map
   // ----------------------------------------------------------------
   localparam logic [11:0] CTRL_ADDR = 12'h000;
   localparam logic [11:0] STAT_ADDR = 12'h004;
   localparam logic [3:0]  VAL_PAGE  = 4'h1;
   localparam int          CTRL_GO   = 8;
   localparam int          CTRL_OFFS = 5;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_HOLD = 3'b010,
      ST_ACQ  = 3'b100
   } acq_state_t;
endpackage

// file: hdl/sync2.sv
/*
 * Two-flip-flop synchroniser for a vector of asynchronous levels.
 * Assumes every bit is an independent level.
 */
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         sys_clk,
   input  wire logic         nrst,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;
   logic [W-1:0] q_ff;

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         meta_ff <= '0;
         q_ff    <= '0;
      end else begin
         meta_ff <= d;
         q_ff    <= meta_ff;
      end
   end

   assign q = q_ff;
endmodule // sync2

// file: hdl/shc_ctrl.sv
/*
 * Channel control: parallel and serial addressing, track/reset pin,
 * acquisition sequencing, channel value store and APB register slave.
 * Assumes pins are asynchronous and adc_code is on sys_clk.
 */
module shc_ctrl
   import shc_pkg::*;
#(
   parameter int VAL_W   = 12,
   parameter int ACQ_CYC = ACQ_MAX_CYC
) (
   input  wire logic             sys_clk,
   input  wire logic             nrst,
   input  wire logic [11:0]      paddr,
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   input  wire pin_in_t          pin_val,
   input  wire logic [PIN_W-1:0] pin_float,
   input  wire logic [4:0]       channel_address,
   input  wire logic [VAL_W-1:0] adc_code,
   output logic                  busy_n,
   output logic                  input_routed,
   output logic                  sdout,
   output chan_sel_t             acq_chan
);
   localparam logic [ACQ_W-1:0] ACQ_LAST = ACQ_W'(ACQ_CYC - 1);
   localparam logic [LO_W-1:0]  LO_MIN   = LO_W'(RST_MIN_CYC);
   localparam logic [LO_W-1:0]  LO_MAX   = LO_W'(RST_MAX_CYC);

   // ----------------------------------------------------------------
   // Pin defaults and synchronisers
   // ----------------------------------------------------------------
   logic [PIN_W-1:0] s_val;
   logic [PIN_W-1:0] s_flt;
   pin_in_t          s_pin;
   pin_in_t          p_pin_ff;
   logic [4:0]       s_addr;

   // Levels cross relative to the idle pattern, so reset reads as idle pins
   sync2 #(.W(2 * PIN_W + 5)) u_sync (
      .sys_clk (sys_clk),
      .nrst    (nrst),
      .d       ({PIN_W'(pin_val) ^ PIN_DEFAULT, pin_float, channel_address}),
      .q       ({s_val, s_flt, s_addr})
   );

   assign s_pin = pin_in_t'(((s_val ^ PIN_DEFAULT) & ~s_flt) | (PIN_DEFAULT & s_flt));

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) p_pin_ff <= pin_in_t'(PIN_DEFAULT);
      else       p_pin_ff <= s_pin;
   end

   logic cs_fall, wr_fall, sclk_fall, sclk_rise, trk_rise, ser_mode;
   assign ser_mode  = s_pin.port_choice;
   assign cs_fall   = p_pin_ff.cs_sync_n & ~s_pin.cs_sync_n;
   assign wr_fall   = p_pin_ff.wr_n & ~s_pin.wr_n;
   assign sclk_fall = p_pin_ff.sclk & ~s_pin.sclk & ~s_pin.cs_sync_n;
   assign sclk_rise = ~p_pin_ff.sclk & s_pin.sclk & ~s_pin.cs_sync_n;
   assign trk_rise  = ~p_pin_ff.track_n & s_pin.track_n;

   // ----------------------------------------------------------------
   // Track/reset pulse measurement
   // ----------------------------------------------------------------
   logic [LO_W-1:0] lo_cnt_ff, nxt_lo_cnt;
   logic            srst, trk_long;

   always_comb begin
      nxt_lo_cnt = lo_cnt_ff;
      if (s_pin.track_n)        nxt_lo_cnt = '0;
      else if (lo_cnt_ff != '1) nxt_lo_cnt = lo_cnt_ff + 1'b1;
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) lo_cnt_ff <= '0;
      else       lo_cnt_ff <= nxt_lo_cnt;
   end

   assign srst     = trk_rise & (lo_cnt_ff >= LO_MIN) & (lo_cnt_ff <= LO_MAX);
   assign trk_long = trk_rise & (lo_cnt_ff > LO_MAX);

   // ----------------------------------------------------------------
   // Addressing: parallel, serial and software
   // ----------------------------------------------------------------
   logic [SER_BITS-1:0] sh_in_ff, nxt_sh_in;
   logic [2:0]          bit_cnt_ff, nxt_bit_cnt;
   logic [VAL_W-1:0]    rb_sh_ff, nxt_rb_sh;
   logic                sdout_ff, nxt_sdout;
   logic                par_ev, ser_ev, sw_ev, addr_ev;
   logic [SER_BITS-1:0] ser_word;
   chan_sel_t           ev_sel;
   chan_sel_t           sel_ff;
   logic [VAL_W-1:0]    val_ff [NUM_CH+1];
   logic [IDX_W-1:0]    sel_idx;

   assign sel_idx  = sel_ff.offs ? OFFS_IDX : {1'b0, sel_ff.ch};
   assign ser_word = {sh_in_ff[SER_BITS-2:0], s_pin.sdin};

   assign par_ev = ~ser_mode & ~s_pin.cs_sync_n & wr_fall;
   // eighth falling edge completes the word
   assign ser_ev = ser_mode & sclk_fall & (bit_cnt_ff == 3'd7);
   assign sw_ev  = psel & penable & pwrite & (paddr == CTRL_ADDR) & pwdata[CTRL_GO];
   assign addr_ev = par_ev | ser_ev | sw_ev;

   always_comb begin
      if (par_ev)      ev_sel = '{offs: s_pin.offset_sel, ch: s_addr};
      else if (ser_ev) ev_sel = '{offs: ser_word[SER_OFFS], ch: ser_word[4:0]};
      else             ev_sel = '{offs: pwdata[CTRL_OFFS], ch: pwdata[4:0]};
   end

   always_comb begin
      nxt_sh_in   = sh_in_ff;
      nxt_bit_cnt = bit_cnt_ff;
      nxt_rb_sh   = rb_sh_ff;
      nxt_sdout   = sdout_ff;
      if (ser_mode) begin
         if (cs_fall) begin
            nxt_bit_cnt = '0;
            nxt_rb_sh   = val_ff[sel_idx];
         end else begin
            if (sclk_fall) begin
               nxt_sh_in   = ser_word;
               nxt_bit_cnt = bit_cnt_ff + 1'b1;
            end
            // shift readback out on rising edge
            if (sclk_rise) begin
               nxt_sdout = rb_sh_ff[VAL_W-1];
               nxt_rb_sh = {rb_sh_ff[VAL_W-2:0], 1'b0};
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         sh_in_ff   <= '0;
         bit_cnt_ff <= '0;
         rb_sh_ff   <= '0;
         sdout_ff   <= 1'b0;
      end else if (srst) begin
         sh_in_ff   <= '0;
         bit_cnt_ff <= '0;
         rb_sh_ff   <= '0;
         sdout_ff   <= 1'b0;
      end else begin
         sh_in_ff   <= nxt_sh_in;
         bit_cnt_ff <= nxt_bit_cnt;
         rb_sh_ff   <= nxt_rb_sh;
         sdout_ff   <= nxt_sdout;
      end
   end

   // ----------------------------------------------------------------
   // Acquisition sequencer
   // ----------------------------------------------------------------
   acq_state_t       state_ff, nxt_state;
   logic [ACQ_W-1:0] acq_cnt_ff, nxt_acq_cnt;
   chan_sel_t        nxt_sel;
   logic             val_we;

   always_comb begin
      nxt_state   = state_ff;
      nxt_acq_cnt = acq_cnt_ff;
      nxt_sel     = sel_ff;
      val_we      = 1'b0;
      unique case (state_ff)
         ST_IDLE, ST_HOLD: begin
            if (addr_ev) begin
               nxt_sel     = ev_sel;
               nxt_acq_cnt = '0;
               // track level decides start or hold
               nxt_state   = s_pin.track_n ? ST_ACQ : ST_HOLD;
            end else if (state_ff == ST_HOLD && trk_long) begin
               nxt_acq_cnt = '0;
               nxt_state   = ST_ACQ;
            end
         end
         ST_ACQ: begin
            nxt_acq_cnt = acq_cnt_ff + 1'b1;
            if (acq_cnt_ff == ACQ_LAST) begin
               val_we    = 1'b1;
               nxt_state = ST_IDLE;
            end
         end
      endcase
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         state_ff   <= ST_IDLE;
         acq_cnt_ff <= '0;
         sel_ff     <= '0;
      end else if (srst) begin
         state_ff   <= ST_IDLE;
         acq_cnt_ff <= '0;
         sel_ff     <= '0;
      end else begin
         state_ff   <= nxt_state;
         acq_cnt_ff <= nxt_acq_cnt;
         sel_ff     <= nxt_sel;
      end
   end

   // values cleared at reset and on reset pulse
   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst) begin
         for (int i = 0; i <= NUM_CH; i++) val_ff[i] <= '0;
      end else if (srst) begin
         for (int i = 0; i <= NUM_CH; i++) val_ff[i] <= '0;
      end else if (val_we) begin
         val_ff[sel_idx] <= adc_code;
      end
   end

   assign busy_n       = (state_ff != ST_ACQ);
   // input routed while held or acquiring
   assign input_routed = (state_ff != ST_IDLE);
   assign sdout        = sdout_ff;
   assign acq_chan     = sel_ff;

   // ----------------------------------------------------------------
   // APB slave
   // ----------------------------------------------------------------
   logic [31:0]      prdata_ff, nxt_prdata;
   logic             hit;
   logic [IDX_W-1:0] rd_idx;

   assign rd_idx = paddr[7:2];
   always_comb begin
      hit        = 1'b1;
      nxt_prdata = prdata_ff;
      if (paddr == CTRL_ADDR) begin
         nxt_prdata = 32'h0;
      end else if (paddr == STAT_ADDR) begin
         nxt_prdata = {21'h0, (state_ff == ST_HOLD), sel_ff, s_pin.track_n,
                       ser_mode, input_routed, ~busy_n};
      end else if (paddr[11:8] == VAL_PAGE && rd_idx <= OFFS_IDX) begin
         nxt_prdata = {{(32 - VAL_W){1'b0}}, val_ff[rd_idx]};
      end else begin
         hit        = 1'b0;
         nxt_prdata = 32'h0;
      end
   end

   always_ff @(posedge sys_clk or negedge nrst) begin
      if (!nrst)                  prdata_ff <= '0;
      else if (psel && !penable)  prdata_ff <= nxt_prdata;
   end

   assign prdata  = prdata_ff;
   assign pready  = psel & penable;
   assign pslverr = psel & penable & ~hit;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   busy_len_a: assert property ($rose(busy_n) && !$past(srst)
      |-> $past(acq_cnt_ff) == ACQ_LAST)
      else $error("busy released at wrong count");
   acq_bound_a: assert property (!busy_n |-> acq_cnt_ff < ACQ_W'(ACQ_MAX_CYC))
      else $error("acquisition overran limit");
   track_start_a: assert property (state_ff == ST_IDLE && addr_ev && !srst
      && s_pin.track_n |=> !busy_n && sel_ff == $past(ev_sel))
      else $error("addressed with track high but no acquisition");
   hold_route_a: assert property (state_ff == ST_HOLD |-> busy_n && input_routed)
      else $error("hold state not routing");
   track_rise_a: assert property (state_ff == ST_HOLD && trk_long && !addr_ev
      |=> !busy_n ##1 !busy_n)
      else $error("track rise did not start acquisition");
   soft_reset_a: assert property (srst |=> state_ff == ST_IDLE && busy_n
      && val_ff[OFFS_IDX] == '0 && val_ff[0] == '0)
      else $error("reset pulse did not clear device");
   glitch_ign_a: assert property (trk_rise && lo_cnt_ff < LO_MIN && !addr_ev
      && state_ff != ST_ACQ |=> $stable(state_ff))
      else $error("glitch changed state");
   par_latch_a: assert property (par_ev && state_ff == ST_IDLE && !srst
      |=> sel_ff.ch == $past(s_addr) && sel_ff.offs == $past(s_pin.offset_sel))
      else $error("parallel address not latched");
   mode_sel_a: assert property (ser_mode && state_ff == ST_IDLE && !ser_ev && !sw_ev
      && !srst |=> state_ff == ST_IDLE)
      else $error("parallel strobe taken in serial mode");
   sdout_shift_a: assert property (ser_mode && sclk_rise && !cs_fall && !srst
      |=> sdout == $past(rb_sh_ff[VAL_W-1]))
      else $error("readback bit not shifted on rising edge");
   ser_shift_a: assert property (ser_mode && sclk_fall && !cs_fall && !srst
      |=> bit_cnt_ff == $past(bit_cnt_ff) + 3'd1)
      else $error("serial bit not counted on falling edge");
endmodule // shc_ctrl

// file: verif/shc_host.sv
/*
 * Host model for the pin side of shc_ctrl: parallel strobes, serial frames
 * and track pulses. Assumes tasks are called from a process on sys_clk.
 */
module shc_host
   import shc_pkg::*;
(
   input  wire logic       sys_clk,
   input  wire logic       sdout,
   output pin_in_t         pins,
   output logic      [4:0] chan_addr
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      pins      = PIN_DEFAULT | 7'h20;
      chan_addr = 5'h00;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   task automatic set_pin(input int b, input logic v);
      tick(1);
      pins[b] <= v;
   endtask

   task automatic par_addr(input logic [5:0] sel, input logic sel_n);
      tick(1);
      chan_addr       <= sel[4:0];
      pins.offset_sel <= sel[5];
      pins.cs_sync_n  <= sel_n;
      tick(4);
      pins.wr_n <= 1'b0;
      tick(4);
      pins.wr_n <= 1'b1;
      tick(4);
      pins.cs_sync_n <= 1'b1;
      chan_addr      <= ~sel[4:0];
   endtask

   // framed word, 160 ns shift clock
   task automatic ser_frame(input logic [7:0] w, output logic [11:0] rb);
      tick(1);
      pins.cs_sync_n <= 1'b0;
      pins.sdin      <= w[7];
      for (int i = 0; i < 13; i++) begin
         tick(8);
         pins.sclk <= 1'b0;
         if (i > 0) rb[12-i] = sdout;
         tick(8);
         pins.sclk <= 1'b1;
         pins.sdin <= (i < 7) ? w[6-i] : i[0];
      end
      tick(8);
      pins.sdin      <= 1'b1;
      pins.cs_sync_n <= 1'b1;
   endtask

   task automatic track_pulse(input int n);
      tick(1);
      pins.track_n <= 1'b0;
      tick(n);
      pins.track_n <= 1'b1;
   endtask
endmodule // shc_host

// file: verif/sample_hold_channel_control_bench.sv
/*
 * Self-checking bench for shc_ctrl: APB master, host model, row loop of
 * parallel acquisitions, then track, reset and serial cases.
 * Assumes the shortened acquisition length ACQ.
 */
module sample_hold_channel_control_bench
   import shc_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int ACQ = 20;
   // Rows: offset, channel, code
   localparam logic [17:0] ROWS [4] = '{{6'h00, 12'h5a5}, {6'h1f, 12'hfff},
                                        {6'h10, 12'h001}, {6'h20, 12'ha3c}};
   logic        sys_clk = 1'b0;
   logic        nrst;
   logic [11:0] paddr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   pin_in_t     pins;
   logic [6:0]  pin_float;
   logic [4:0]  chan_addr;
   logic [11:0] adc_code;
   logic        busy_n;
   logic        input_routed;
   logic        sdout;
   chan_sel_t   acq_chan;
   int          n_mismatch = 0;
   int          comparisons = 0;
   int          n;
   logic [11:0] rb;
   logic [31:0] d;
   logic        e;

   always #5 sys_clk = ~sys_clk;

   shc_ctrl #(.ACQ_CYC(ACQ)) i_shc_ctrl (
      .sys_clk(sys_clk), .nrst(nrst), .paddr(paddr), .psel(psel), .penable(penable),
      .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .pin_val(pins), .pin_float(pin_float), .channel_address(chan_addr),
      .adc_code(adc_code), .busy_n(busy_n), .input_routed(input_routed), .sdout(sdout),
      .acq_chan(acq_chan));

   shc_host i_shc_host (.sys_clk(sys_clk), .sdout(sdout), .pins(pins), .chan_addr(chan_addr));

   task automatic stop_test;
      $display("Comparisons %0d, mismatches %0d", comparisons, n_mismatch);
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      comparisons++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] wd);
      int k;
      @(posedge sys_clk);
      psel   <= 1'b1;
      pwrite <= w;
      paddr  <= a;
      pwdata <= wd;
      @(posedge sys_clk);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge sys_clk);
         k++;
      end while (pready !== 1'b1 && k < 50);
      d = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      chk("pready wait", 32'h1, {31'h0, pready});
   endtask

   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(a, 1'b0, 32'h0);
      chk($sformatf("prdata %h", a), exp, d);
   endtask

   task automatic wait_busy(input logic lvl);
      n = 0;
      while (busy_n !== lvl && n < 300) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (n == 300) begin
         chk("busy_n wait", {31'h0, lvl}, {31'h0, busy_n});
         stop_test;
      end
   endtask

   task automatic acq_span;
      wait_busy(1'b0);
      wait_busy(1'b1);
      chk("busy_n low cycles", ACQ, n);
   endtask

   initial begin
      repeat (20000) @(posedge sys_clk);
      n_mismatch++;
      stop_test;
   end

   initial begin
      nrst     = 1'b0;
      psel     = 1'b0;
      penable  = 1'b0;
      pwrite   = 1'b0;
      paddr    = 12'h000;
      pwdata   = 32'h0;
      adc_code = 12'h000;
      pin_float = 7'h00;
      repeat (16) @(posedge sys_clk);
      nrst <= 1'b1;
      i_shc_host.tick(4);
      chk("busy_n reset", 32'h1, {31'h0, busy_n});
      rd_chk(12'h100, 32'h0);
      rd_chk(12'h180, 32'h0);
      foreach (ROWS[k]) begin
         @(posedge sys_clk);
         adc_code <= ROWS[k][11:0];
         fork
            i_shc_host.par_addr(ROWS[k][17:12], 1'b0);
            acq_span();
         join
         chk("acq_chan", {26'h0, ROWS[k][17:12]}, {26'h0, acq_chan});
         rd_chk(ROWS[k][17] ? 12'h180 : {4'h1, 1'b0, ROWS[k][16:12], 2'h0}, ROWS[k][11:0]);
      end
      i_shc_host.par_addr(6'h05, 1'b1);
      i_shc_host.tick(20);
      chk("busy_n no select", 32'h1, {31'h0, busy_n});
      chk("acq_chan no select", 32'h20, {26'h0, acq_chan});
      apb(12'h0f0, 1'b0, 32'h0);
      chk("pslverr", 32'h1, {31'h0, e});
      i_shc_host.set_pin(1, 1'b0);
      i_shc_host.tick(30);
      adc_code <= 12'h3c7;
      i_shc_host.par_addr(6'h03, 1'b0);
      i_shc_host.tick(30);
      chk("busy_n held", 32'h1, {31'h0, busy_n});
      chk("input_routed", 32'h1, {31'h0, input_routed});
      fork
         i_shc_host.set_pin(1, 1'b1);
         acq_span();
      join
      rd_chk(12'h10c, 32'h3c7);
      i_shc_host.track_pulse(5);
      i_shc_host.tick(30);
      chk("busy_n glitch", 32'h1, {31'h0, busy_n});
      rd_chk(12'h10c, 32'h3c7);
      i_shc_host.track_pulse(14);
      i_shc_host.tick(10);
      rd_chk(12'h10c, 32'h0);
      rd_chk(12'h180, 32'h0);
      chk("acq_chan reset", 32'h0, {26'h0, acq_chan});
      i_shc_host.set_pin(0, 1'b1);
      i_shc_host.par_addr(6'h02, 1'b0);
      i_shc_host.tick(20);
      chk("busy_n serial mode", 32'h1, {31'h0, busy_n});
      chk("acq_chan serial mode", 32'h0, {26'h0, acq_chan});
      adc_code <= 12'h6c3;
      i_shc_host.ser_frame(8'h09, rb);
      chk("readback cleared", 32'h0, {20'h0, rb});
      chk("acq_chan serial", 32'h9, {26'h0, acq_chan});
      rd_chk(12'h124, 32'h6c3);
      i_shc_host.ser_frame(8'h89, rb);
      chk("readback", 32'h6c3, {20'h0, rb});
      i_shc_host.tick(40);
      rd_chk(12'h180, 32'h6c3);
      adc_code  <= 12'h2b4;
      pin_float <= 7'h03;
      i_shc_host.set_pin(1, 1'b0);
      fork
         i_shc_host.par_addr(6'h07, 1'b0);
         acq_span();
      join
      chk("acq_chan floating", 32'h7, {26'h0, acq_chan});
      rd_chk(12'h11c, 32'h2b4);
      adc_code <= 12'h1e1;
      fork
         apb(CTRL_ADDR, 1'b1, 32'h0000_0112);
         acq_span();
      join
      chk("acq_chan software", 32'h12, {26'h0, acq_chan});
      rd_chk(12'h148, 32'h1e1);
      rd_chk(STAT_ADDR, 32'h0000_0128);
      stop_test;
   end
endmodule // sample_hold_channel_control_bench
